// ==== hw/diag_reset_pkg.sv ====
package diag_reset_pkg;

  // device clock and protocol times, each in its own unit
  localparam longint unsigned CLK_HZ = 64'd250_000_000;
  localparam longint unsigned PDIAG_WAIT_MS = 64'd1;
  localparam longint unsigned PDIAG_TIMEOUT_S = 64'd6;
  localparam longint unsigned RELEASE_MAX_NS = 64'd400;

  // cycle counts; the least wait is exact at this rate, the timeout is an exact product
  localparam longint unsigned PDIAG_WAIT_CYC = (CLK_HZ * PDIAG_WAIT_MS + 64'd999) / 64'd1000;
  localparam longint unsigned PDIAG_TIMEOUT_CYC = CLK_HZ * PDIAG_TIMEOUT_S;
  localparam longint unsigned RELEASE_MAX_CYC = (CLK_HZ / 64'd1_000_000) * RELEASE_MAX_NS / 64'd1000;

  localparam int CNT_W = 32;

  // error register layout
  localparam int ERR_COMPANION_BIT = 7;
  localparam logic [7:0] ERR_RESET_VAL = 8'h01;

  // status bits cleared at completion
  localparam logic [7:0] STAT_CLR_PLAIN = 8'h0d;   // bits 3, 2, 0
  localparam logic [7:0] STAT_CLR_PACKET = 8'h7d;  // bits 6, 5, 4, 3, 2, 0

  // signature values
  localparam logic [7:0] SIG_SECT_CNT = 8'h01;
  localparam logic [7:0] SIG_SECT_NUM = 8'h01;
  localparam logic [7:0] SIG_CYL_LO_PLAIN = 8'h00;
  localparam logic [7:0] SIG_CYL_HI_PLAIN = 8'h00;
  localparam logic [7:0] SIG_CYL_LO_PACKET = 8'h14;
  localparam logic [7:0] SIG_CYL_HI_PACKET = 8'heb;

  // index of each signature register in the host write strobes
  localparam int SIG_IDX_CNT = 0;
  localparam int SIG_IDX_NUM = 1;
  localparam int SIG_IDX_CLO = 2;
  localparam int SIG_IDX_CHI = 3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_D0_WAIT = 4'h1,
    ST_D0_SAMPLE = 4'h2,
    ST_D0_STATUS = 4'h3,
    ST_D1_NEGATE = 4'h4,
    ST_D1_STATUS = 4'h5,
    ST_DR_STATUS = 4'h6
  } state_t;

endpackage : diag_reset_pkg

// ==== hw/diag_reset_ctl.sv ====
`timescale 1ns/10ps

// Behaviour
// - no companion seen: clear bit7, set status
// - companion present: wait 1 ms first
// - companion pass seen: clear bit7, set status
// - keep sampling until pass or 6 s
// - 6 s timeout: set bit7, set status
// - finish self-test, write code, load signature
// - clear status bits by packet capability
// - packet device restores operating modes after diagnostic
// - clear busy; interrupt only when nien zero
// - second drive: release bus, busy, clear dev
// - second drive negates pass line within 1 ms
// - second drive: result, signature, pass if good
// - second drive: clear busy, no interrupt
// - reset pin or srst during a diagnostic or device reset restarts reset protocols
// - device reset: release bus, set busy
// - device reset abandons commands and background work
// - device reset keeps mode settings unchanged
// - device reset: signature, bit7 clear, status clear
// - device reset: clear busy, selected idle, no interrupt
// - packet signature 01 01 14 eb
// - signature held until drdy command or host write
module diag_reset_ctl #(
  parameter logic [31:0] PDIAG_WAIT_CYC = 32'(diag_reset_pkg::PDIAG_WAIT_CYC),
  parameter logic [31:0] PDIAG_TIMEOUT_CYC = 32'(diag_reset_pkg::PDIAG_TIMEOUT_CYC)
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic diag_cmd,
  input wire logic dev_reset_cmd,
  input wire logic is_second_drive,
  input wire logic companion_present,
  input wire logic packet_set,
  input wire logic nien,
  input wire logic srst,
  input wire logic hw_reset_pin_b,
  input wire logic pdiag_in_b,
  input wire logic selftest_done,
  input wire logic selftest_pass,
  input wire logic [6:0] selftest_code,
  input wire logic status_rd,
  input wire logic drdy_cmd,
  input wire logic [3:0] host_sig_wr,
  input wire logic [7:0] host_wr_data,
  output logic bsy,
  output logic intrq,
  output logic bus_release,
  output logic dev_clear,
  output logic pdiag_out_b,
  output logic pdiag_oe,
  output logic [7:0] error_reg,
  output logic status_clear,
  output logic [7:0] status_clear_mask,
  output logic [7:0] sig_sect_cnt,
  output logic [7:0] sig_sect_num,
  output logic [7:0] sig_cyl_lo,
  output logic [7:0] sig_cyl_hi,
  output logic sig_valid,
  output logic mode_restore,
  output logic abort_cmd,
  output logic hw_restart,
  output logic sw_restart,
  output logic idle_selected,
  output logic idle_not_selected
);

  // elaboration checks on the window counts
  if (PDIAG_WAIT_CYC == 32'h0 || PDIAG_TIMEOUT_CYC <= PDIAG_WAIT_CYC) begin : g_bad_cnt
    $error("timeout count must exceed a non-zero wait count");
  end

  typedef struct packed {
    diag_reset_pkg::state_t st;
    logic [31:0] cnt;
    logic pd_m, pd_s, rp_m, rp_s, rp_d;
    logic bsy, intrq, bus_rel, dev_clr, pdiag_oe;
    logic [7:0] err;
    logic st_clr;
    logic [7:0] st_mask;
    logic [7:0] sig_cnt, sig_num, sig_clo, sig_chi;
    logic sig_ok, mode_rst, abort, hw_rst, sw_rst, idle_sel, idle_nsel;
  } ctl_t;

  logic [1:0] rst_sync_ff;
  logic rst_sync_b;
  ctl_t ctl_ff, nxt_ctl;
  logic busy_cmd, reset_hit, finish;
  logic [7:0] sig_lo_val, sig_hi_val;

  // reset released through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_sync_ff[1];

  // a diagnostic or device reset is in progress
  assign busy_cmd = (ctl_ff.st != diag_reset_pkg::ST_IDLE);
  // reset pin falling edge, seen on the synchronised copy only
  assign reset_hit = ctl_ff.rp_d && !ctl_ff.rp_s;
  assign sig_lo_val = packet_set ? diag_reset_pkg::SIG_CYL_LO_PACKET : diag_reset_pkg::SIG_CYL_LO_PLAIN;
  assign sig_hi_val = packet_set ? diag_reset_pkg::SIG_CYL_HI_PACKET : diag_reset_pkg::SIG_CYL_HI_PLAIN;

  // next-state logic for the whole block
  always_comb begin
    nxt_ctl = ctl_ff;
    finish = 1'b0;
    // pulses last one cycle
    nxt_ctl.dev_clr = 1'b0;
    nxt_ctl.st_clr = 1'b0;
    nxt_ctl.mode_rst = 1'b0;
    nxt_ctl.abort = 1'b0;
    nxt_ctl.hw_rst = 1'b0;
    nxt_ctl.sw_rst = 1'b0;
    // pin synchronisers: the first flop feeds only the second
    nxt_ctl.pd_m = pdiag_in_b;
    nxt_ctl.pd_s = ctl_ff.pd_m;
    nxt_ctl.rp_m = hw_reset_pin_b;
    nxt_ctl.rp_s = ctl_ff.rp_m;
    nxt_ctl.rp_d = ctl_ff.rp_s;
    // host status read drops a pending interrupt
    if (status_rd) begin
      nxt_ctl.intrq = 1'b0;
    end
    // a command that sets drdy frees the signature
    if (drdy_cmd) begin
      nxt_ctl.sig_ok = 1'b0;
    end
    // host writes replace the value and spoil the signature
    if (host_sig_wr[diag_reset_pkg::SIG_IDX_CNT]) begin
      nxt_ctl.sig_cnt = host_wr_data;
    end
    if (host_sig_wr[diag_reset_pkg::SIG_IDX_NUM]) begin
      nxt_ctl.sig_num = host_wr_data;
    end
    if (host_sig_wr[diag_reset_pkg::SIG_IDX_CLO]) begin
      nxt_ctl.sig_clo = host_wr_data;
    end
    if (host_sig_wr[diag_reset_pkg::SIG_IDX_CHI]) begin
      nxt_ctl.sig_chi = host_wr_data;
    end
    if (|host_sig_wr) begin
      nxt_ctl.sig_ok = 1'b0;
    end

    unique case (ctl_ff.st)
      diag_reset_pkg::ST_IDLE: begin
        nxt_ctl.cnt = 32'h0;
        if (diag_cmd) begin
          // release the bus and go busy at once, well inside 400 ns
          nxt_ctl.bsy = 1'b1;
          nxt_ctl.bus_rel = 1'b1;
          nxt_ctl.dev_clr = 1'b1;
          nxt_ctl.intrq = 1'b0;
          nxt_ctl.idle_sel = 1'b0;
          nxt_ctl.idle_nsel = 1'b0;
          nxt_ctl.pdiag_oe = 1'b0;
          if (is_second_drive) begin
            nxt_ctl.st = diag_reset_pkg::ST_D1_NEGATE;
          end else if (companion_present) begin
            nxt_ctl.st = diag_reset_pkg::ST_D0_WAIT;
          end else begin
            nxt_ctl.err[diag_reset_pkg::ERR_COMPANION_BIT] = 1'b0;
            nxt_ctl.st = diag_reset_pkg::ST_D0_STATUS;
          end
        end else if (dev_reset_cmd) begin
          nxt_ctl.bsy = 1'b1;
          nxt_ctl.bus_rel = 1'b1;
          nxt_ctl.intrq = 1'b0;
          nxt_ctl.idle_sel = 1'b0;
          nxt_ctl.idle_nsel = 1'b0;
          nxt_ctl.abort = 1'b1;
          nxt_ctl.st = diag_reset_pkg::ST_DR_STATUS;
        end
      end
      diag_reset_pkg::ST_D0_WAIT: begin
        // counts cycles since the command was written
        nxt_ctl.cnt = ctl_ff.cnt + 32'h1;
        if (ctl_ff.cnt >= PDIAG_WAIT_CYC - 32'h1) begin
          nxt_ctl.st = diag_reset_pkg::ST_D0_SAMPLE;
        end
      end
      diag_reset_pkg::ST_D0_SAMPLE: begin
        nxt_ctl.cnt = ctl_ff.cnt + 32'h1;
        if (!ctl_ff.pd_s) begin
          nxt_ctl.err[diag_reset_pkg::ERR_COMPANION_BIT] = 1'b0;
          nxt_ctl.st = diag_reset_pkg::ST_D0_STATUS;
        end else if (ctl_ff.cnt >= PDIAG_TIMEOUT_CYC - 32'h1) begin
          nxt_ctl.err[diag_reset_pkg::ERR_COMPANION_BIT] = 1'b1;
          nxt_ctl.st = diag_reset_pkg::ST_D0_STATUS;
        end else begin
          nxt_ctl.st = diag_reset_pkg::ST_D0_SAMPLE;
        end
      end
      diag_reset_pkg::ST_D0_STATUS: begin
        // holds busy until the local self-test reports
        if (selftest_done) begin
          finish = 1'b1;
          nxt_ctl.err[6:0] = selftest_code;
          nxt_ctl.st_mask = packet_set ? diag_reset_pkg::STAT_CLR_PACKET : diag_reset_pkg::STAT_CLR_PLAIN;
          nxt_ctl.mode_rst = packet_set;
          nxt_ctl.intrq = !nien;
          nxt_ctl.idle_sel = 1'b1;
        end
      end
      diag_reset_pkg::ST_D1_NEGATE: begin
        // pass line already released on entry, far inside 1 ms
        nxt_ctl.pdiag_oe = 1'b0;
        nxt_ctl.st = diag_reset_pkg::ST_D1_STATUS;
      end
      diag_reset_pkg::ST_D1_STATUS: begin
        if (selftest_done) begin
          finish = 1'b1;
          nxt_ctl.err = {1'b0, selftest_code};
          nxt_ctl.pdiag_oe = selftest_pass;
          nxt_ctl.st_mask = packet_set ? diag_reset_pkg::STAT_CLR_PACKET : diag_reset_pkg::STAT_CLR_PLAIN;
          nxt_ctl.mode_rst = packet_set;
          nxt_ctl.idle_nsel = 1'b1;
        end
      end
      diag_reset_pkg::ST_DR_STATUS: begin
        // mode settings untouched, so no unit attention is owed
        finish = 1'b1;
        nxt_ctl.err[diag_reset_pkg::ERR_COMPANION_BIT] = 1'b0;
        nxt_ctl.st_mask = diag_reset_pkg::STAT_CLR_PACKET;
        nxt_ctl.mode_rst = 1'b0;
        nxt_ctl.intrq = 1'b0;
        nxt_ctl.idle_sel = 1'b1;
      end
      default: begin
        nxt_ctl.st = diag_reset_pkg::ST_IDLE;
      end
    endcase

    // shared completion; the hardware load wins over a host write in the same cycle
    if (finish) begin
      nxt_ctl.sig_cnt = diag_reset_pkg::SIG_SECT_CNT;
      nxt_ctl.sig_num = diag_reset_pkg::SIG_SECT_NUM;
      nxt_ctl.sig_clo = sig_lo_val;
      nxt_ctl.sig_chi = sig_hi_val;
      nxt_ctl.sig_ok = 1'b1;
      nxt_ctl.st_clr = 1'b1;
      nxt_ctl.bsy = 1'b0;
      nxt_ctl.bus_rel = 1'b0;
      nxt_ctl.st = diag_reset_pkg::ST_IDLE;
    end

    // reset requests mid-command hand over to the reset protocols
    if (busy_cmd && (reset_hit || srst)) begin
      nxt_ctl.hw_rst = reset_hit;
      nxt_ctl.sw_rst = !reset_hit;
      nxt_ctl.bsy = 1'b0;
      nxt_ctl.bus_rel = 1'b0;
      nxt_ctl.st_clr = 1'b0;
      nxt_ctl.mode_rst = 1'b0;
      nxt_ctl.intrq = 1'b0;
      nxt_ctl.idle_sel = 1'b0;
      nxt_ctl.idle_nsel = 1'b0;
      nxt_ctl.st = diag_reset_pkg::ST_IDLE;
    end
  end

  // the whole state in one register; clk_en low freezes it
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctl_ff <= '{st: diag_reset_pkg::ST_IDLE, cnt: 32'h0, pd_m: 1'b1, pd_s: 1'b1,
                  rp_m: 1'b1, rp_s: 1'b1, rp_d: 1'b1, err: diag_reset_pkg::ERR_RESET_VAL,
                  st_mask: 8'h00, sig_cnt: 8'h00, sig_num: 8'h00, sig_clo: 8'h00,
                  sig_chi: 8'h00, default: 1'b0};
    end else if (clk_en) begin
      ctl_ff <= nxt_ctl;
    end
  end

  // outputs straight from the state register; pdiag_out_b is tied low
  assign bsy = ctl_ff.bsy;
  assign intrq = ctl_ff.intrq;
  assign bus_release = ctl_ff.bus_rel;
  assign dev_clear = ctl_ff.dev_clr;
  assign pdiag_out_b = 1'b0;
  assign pdiag_oe = ctl_ff.pdiag_oe;
  assign error_reg = ctl_ff.err;
  assign status_clear = ctl_ff.st_clr;
  assign status_clear_mask = ctl_ff.st_mask;
  assign sig_sect_cnt = ctl_ff.sig_cnt;
  assign sig_sect_num = ctl_ff.sig_num;
  assign sig_cyl_lo = ctl_ff.sig_clo;
  assign sig_cyl_hi = ctl_ff.sig_chi;
  assign sig_valid = ctl_ff.sig_ok;
  assign mode_restore = ctl_ff.mode_rst;
  assign abort_cmd = ctl_ff.abort;
  assign hw_restart = ctl_ff.hw_rst;
  assign sw_restart = ctl_ff.sw_rst;
  assign idle_selected = ctl_ff.idle_sel;
  assign idle_not_selected = ctl_ff.idle_nsel;

  // checks; each assumes clk_en high in the cycles it spans
  default clocking dflt_cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_b);

  logic quiet;
  assign quiet = clk_en && !srst && ctl_ff.rp_s && ctl_ff.rp_d;

  no_companion_a: assert property (
    quiet && ctl_ff.st == diag_reset_pkg::ST_IDLE && diag_cmd && !is_second_drive && !companion_present
    |=> ctl_ff.st == diag_reset_pkg::ST_D0_STATUS && !ctl_ff.err[diag_reset_pkg::ERR_COMPANION_BIT]
  ) else $error("missing companion did not skip to status");
  wait_window_a: assert property (
    ctl_ff.st == diag_reset_pkg::ST_D0_SAMPLE && $past(ctl_ff.st) == diag_reset_pkg::ST_D0_WAIT
    |-> ctl_ff.cnt == PDIAG_WAIT_CYC
  ) else $error("sampling began before the wait elapsed");
  pass_seen_a: assert property (
    quiet && ctl_ff.st == diag_reset_pkg::ST_D0_SAMPLE && !ctl_ff.pd_s
    |=> ctl_ff.st == diag_reset_pkg::ST_D0_STATUS && !ctl_ff.err[diag_reset_pkg::ERR_COMPANION_BIT]
  ) else $error("companion pass not taken");
  keep_sampling_a: assert property (
    quiet && ctl_ff.st == diag_reset_pkg::ST_D0_SAMPLE && ctl_ff.pd_s
    && ctl_ff.cnt < PDIAG_TIMEOUT_CYC - 32'h1
    |=> ctl_ff.st == diag_reset_pkg::ST_D0_SAMPLE
  ) else $error("sampling left early");
  timeout_flag_a: assert property (
    quiet && ctl_ff.st == diag_reset_pkg::ST_D0_SAMPLE && ctl_ff.pd_s
    && ctl_ff.cnt == PDIAG_TIMEOUT_CYC - 32'h1
    |=> ctl_ff.err[diag_reset_pkg::ERR_COMPANION_BIT] && ctl_ff.st == diag_reset_pkg::ST_D0_STATUS
  ) else $error("timeout did not flag the companion");
  d0_finish_a: assert property (
    quiet && ctl_ff.st == diag_reset_pkg::ST_D0_STATUS && selftest_done
    |=> !ctl_ff.bsy && ctl_ff.intrq == !$past(nien) && ctl_ff.err[6:0] == $past(selftest_code)
  ) else $error("first drive completion wrong");
  d1_finish_a: assert property (
    quiet && ctl_ff.st == diag_reset_pkg::ST_D1_STATUS && selftest_done
    |=> !ctl_ff.bsy && !ctl_ff.intrq && ctl_ff.pdiag_oe == $past(selftest_pass) && ctl_ff.idle_nsel
  ) else $error("second drive completion wrong");
  busy_on_cmd_a: assert property (
    quiet && ctl_ff.st == diag_reset_pkg::ST_IDLE && (diag_cmd || dev_reset_cmd)
    |=> ctl_ff.bsy && ctl_ff.bus_rel && !ctl_ff.intrq
  ) else $error("busy or release late");
  dr_status_a: assert property (
    quiet && ctl_ff.st == diag_reset_pkg::ST_IDLE && !diag_cmd && dev_reset_cmd ##1 quiet
    |=> !ctl_ff.bsy && !ctl_ff.intrq && ctl_ff.sig_ok && ctl_ff.st_mask == diag_reset_pkg::STAT_CLR_PACKET
  ) else $error("device reset status wrong");
  reset_abort_a: assert property (
    clk_en && busy_cmd && srst |=> ctl_ff.st == diag_reset_pkg::ST_IDLE && (ctl_ff.sw_rst || ctl_ff.hw_rst)
  ) else $error("reset request not honoured");
  packet_sig_a: assert property (
    ctl_ff.st_clr && $past(packet_set) && !$past(host_sig_wr[diag_reset_pkg::SIG_IDX_CLO])
    |-> ctl_ff.sig_clo == diag_reset_pkg::SIG_CYL_LO_PACKET
  ) else $error("packet signature wrong");
  // the sequence is declared ahead of the cover that names it
  sequence timeout_flag_a_trig;
    ctl_ff.st == diag_reset_pkg::ST_D0_SAMPLE ##1 ctl_ff.err[diag_reset_pkg::ERR_COMPANION_BIT];
  endsequence
  cover_timeout_c: cover property (timeout_flag_a_trig);
  cover_d1_pass_c: cover property (ctl_ff.st == diag_reset_pkg::ST_D1_STATUS ##1 ctl_ff.pdiag_oe);
  cover_dev_reset_c: cover property (ctl_ff.st == diag_reset_pkg::ST_DR_STATUS ##1 ctl_ff.idle_sel);
  cover_srst_c: cover property (ctl_ff.sw_rst);

endmodule : diag_reset_ctl

// ==== dv/companion_model.sv ====
`timescale 1ns/10ps

// second drive on the cable, seen only through its pass line
module companion_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cmd,
  input wire logic will_pass,
  input wire logic [7:0] pass_after,
  output logic drive_low
);
  logic [7:0] cnt_ff;

  // lets go of the line at the command, pulls it low once its test has passed
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 8'h00;
      drive_low <= 1'b0;
    end else if (cmd) begin
      cnt_ff <= 8'h00;
      drive_low <= 1'b0;
    end else begin
      if (cnt_ff != 8'hff) begin
        cnt_ff <= cnt_ff + 8'h01; // saturates, so a late pass never wraps
      end
      if (will_pass && cnt_ff == pass_after) begin
        drive_low <= 1'b1;
      end
    end
  end
endmodule : companion_model

// ==== dv/diag_and_device_reset_protocol_test.sv ====
`timescale 1ns/10ps

module diag_and_device_reset_protocol_test;
  logic core_clk, rst_b, clk_en, diag_cmd, dev_reset_cmd, is_second_drive, companion_present;
  logic packet_set, nien, srst, hw_reset_pin_b, selftest_done, selftest_pass, status_rd, drdy_cmd;
  logic [6:0] selftest_code;
  logic [3:0] host_sig_wr;
  logic [7:0] host_wr_data, pass_after;
  logic will_pass, drive_low, pdiag_in_b;
  logic bsy, intrq, bus_release, dev_clear, pdiag_out_b, pdiag_oe, status_clear, sig_valid;
  logic mode_restore, abort_cmd, hw_restart, sw_restart, idle_selected, idle_not_selected;
  logic [7:0] error_reg, status_clear_mask, sig_sect_cnt, sig_sect_num, sig_cyl_lo, sig_cyl_hi;
  int err_count = 0;
  int num_checks = 0;

  // pass line is pulled up; either drive may pull it low
  assign pdiag_in_b = !((pdiag_oe && !pdiag_out_b) || drive_low);

  diag_reset_ctl #(.PDIAG_WAIT_CYC(32'd20), .PDIAG_TIMEOUT_CYC(32'd60)) DUT (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .diag_cmd(diag_cmd),
    .dev_reset_cmd(dev_reset_cmd), .is_second_drive(is_second_drive),
    .companion_present(companion_present), .packet_set(packet_set), .nien(nien), .srst(srst),
    .hw_reset_pin_b(hw_reset_pin_b), .pdiag_in_b(pdiag_in_b), .selftest_done(selftest_done),
    .selftest_pass(selftest_pass), .selftest_code(selftest_code), .status_rd(status_rd),
    .drdy_cmd(drdy_cmd), .host_sig_wr(host_sig_wr), .host_wr_data(host_wr_data), .bsy(bsy),
    .intrq(intrq), .bus_release(bus_release), .dev_clear(dev_clear), .pdiag_out_b(pdiag_out_b),
    .pdiag_oe(pdiag_oe), .error_reg(error_reg), .status_clear(status_clear),
    .status_clear_mask(status_clear_mask), .sig_sect_cnt(sig_sect_cnt), .sig_sect_num(sig_sect_num),
    .sig_cyl_lo(sig_cyl_lo), .sig_cyl_hi(sig_cyl_hi), .sig_valid(sig_valid),
    .mode_restore(mode_restore), .abort_cmd(abort_cmd), .hw_restart(hw_restart),
    .sw_restart(sw_restart), .idle_selected(idle_selected), .idle_not_selected(idle_not_selected)
  );

  companion_model partner (
    .core_clk(core_clk), .rst_b(rst_b), .cmd(diag_cmd), .will_pass(will_pass),
    .pass_after(pass_after), .drive_low(drive_low)
  );

  // 250 MHz
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask : chk

  // land just past an edge so registered outputs have settled
  task automatic cyc;
    @(posedge core_clk);
    #1;
  endtask : cyc

  // one-cycle command pulse; returns in the first cycle after it was taken
  task automatic issue(input logic d, input logic r);
    @(posedge core_clk);
    diag_cmd <= d;
    dev_reset_cmd <= r;
    @(posedge core_clk);
    diag_cmd <= 1'b0;
    dev_reset_cmd <= 1'b0;
    #1;
  endtask : issue

  task automatic done_pulse(input logic [6:0] code);
    @(posedge core_clk);
    selftest_done <= 1'b1;
    selftest_code <= code;
    @(posedge core_clk);
    selftest_done <= 1'b0;
    #1;
  endtask : done_pulse

  task automatic rd_status;
    @(posedge core_clk);
    status_rd <= 1'b1;
    @(posedge core_clk);
    status_rd <= 1'b0;
    #1;
  endtask : rd_status

  // bounded wait for busy to drop, n counts edges
  task automatic wait_idle(input int max, output int n);
    n = 0;
    while (bsy !== 1'b0 && n < max) begin
      cyc();
      n++;
    end
  endtask : wait_idle

  task automatic t_dev_reset;
    packet_set <= 1'b1; // device reset belongs to packet-capable drives
    issue(1'b0, 1'b1);
    chk(bsy, 1'b1, "reset busy");
    chk(bus_release, 1'b1, "reset release");
    chk(abort_cmd, 1'b1, "abort");
    cyc();
    chk(bsy, 1'b0, "reset done");
    chk({intrq, idle_selected, mode_restore}, 3'b010, "idle no irq");
    chk({status_clear, status_clear_mask}, 9'h17d, "status clear");
    chk(error_reg[7], 1'b0, "err7");
    chk({sig_sect_cnt, sig_sect_num, sig_cyl_lo, sig_cyl_hi}, 32'h010114eb, "sig");
    chk(sig_valid, 1'b1, "sig valid");
    repeat (100) cyc();
    rd_status();
    chk(bsy, 1'b0, "host poll");
    @(posedge core_clk);
    host_sig_wr <= 4'h4;
    host_wr_data <= 8'h5a;
    @(posedge core_clk);
    host_sig_wr <= 4'h0;
    #1;
    chk({sig_cyl_lo, sig_valid}, 9'h0b4, "host write");
    issue(1'b0, 1'b1);
    cyc();
    @(posedge core_clk);
    drdy_cmd <= 1'b1;
    @(posedge core_clk);
    drdy_cmd <= 1'b0;
    #1;
    chk(sig_valid, 1'b0, "drdy cmd");
    $display("test dev_reset done");
  endtask : t_dev_reset

  task automatic t_diag_plain(input logic ni, input logic pk);
    int n;
    nien <= ni;
    packet_set <= pk;
    companion_present <= 1'b0;
    is_second_drive <= 1'b0;
    issue(1'b1, 1'b0);
    chk({bsy, dev_clear, error_reg[7]}, 3'b110, "d0 start");
    cyc();
    done_pulse(7'h2a);
    wait_idle(10, n);
    chk({bsy, intrq, idle_selected}, {1'b0, !ni, 1'b1}, "d0 end");
    chk(error_reg, 8'h2a, "d0 code");
    chk({status_clear, status_clear_mask}, pk ? 9'h17d : 9'h10d, "d0 mask");
    chk(mode_restore, pk, "modes");
    chk({sig_sect_cnt, sig_cyl_hi}, pk ? 16'h01eb : 16'h0100, "d0 sig");
    rd_status();
    chk(intrq, 1'b0, "irq clear");
    $display("test diag_plain %0d%0d done", ni, pk);
  endtask : t_diag_plain

  task automatic t_diag_comp(input logic wp, input logic [7:0] pa, input int lo, input int hi,
                             input logic e7);
    int n;
    nien <= 1'b1;
    packet_set <= 1'b0;
    companion_present <= 1'b1;
    is_second_drive <= 1'b0;
    selftest_done <= 1'b1;
    selftest_code <= 7'h01;
    will_pass <= wp;
    pass_after <= pa;
    issue(1'b1, 1'b0);
    wait_idle(200, n);
    chk(n >= lo && n <= hi, 1'b1, "window");
    chk({bsy, intrq, error_reg}, {2'b00, e7, 7'h01}, "d0 pass flag");
    selftest_done <= 1'b0;
    $display("test diag_comp %0d done", pa);
  endtask : t_diag_comp

  task automatic t_diag_dev1(input logic ps);
    int n;
    is_second_drive <= 1'b1;
    nien <= 1'b0;
    selftest_pass <= ps;
    issue(1'b1, 1'b0);
    chk({bsy, bus_release, dev_clear, pdiag_oe}, 4'b1110, "d1 start");
    cyc();
    done_pulse(7'h05);
    wait_idle(10, n);
    chk({bsy, intrq, idle_not_selected}, 3'b001, "d1 end");
    chk({error_reg, pdiag_oe, sig_sect_num}, {8'h05, ps, 8'h01}, "d1 result");
    chk(pdiag_out_b, 1'b0, "pass level");
    $display("test diag_dev1 %0d done", ps);
  endtask : t_diag_dev1

  task automatic t_abort(input logic pin);
    logic hs, ss;
    hs = 1'b0;
    ss = 1'b0;
    is_second_drive <= 1'b0;
    companion_present <= 1'b1;
    will_pass <= 1'b0;
    issue(1'b1, 1'b0);
    cyc();
    if (pin) hw_reset_pin_b <= 1'b0;
    else srst <= 1'b1;
    repeat (8) begin
      cyc();
      hs = hs | hw_restart;
      ss = ss | sw_restart;
    end
    chk({bsy, hs, ss}, {1'b0, pin, !pin}, "restart");
    hw_reset_pin_b <= 1'b1;
    srst <= 1'b0;
    repeat (6) cyc();
    $display("test abort %0d done", pin);
  endtask : t_abort

  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    {diag_cmd, dev_reset_cmd, is_second_drive, companion_present, packet_set, nien} = 6'h00;
    {srst, selftest_done, selftest_pass, status_rd, drdy_cmd, will_pass} = 6'h00;
    hw_reset_pin_b = 1'b1;
    selftest_code = 7'h00;
    host_sig_wr = 4'h0;
    host_wr_data = 8'h00;
    pass_after = 8'h00;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) cyc();
    t_dev_reset();
    for (int i = 0; i < 4; i++) t_diag_plain(i[0], i[1]);
    t_diag_comp(1'b0, 8'd0, 58, 70, 1'b1);
    t_diag_plain(1'b1, 1'b0);
    t_diag_comp(1'b0, 8'd0, 58, 70, 1'b1);
    t_diag_comp(1'b1, 8'd3, 18, 30, 1'b0);
    t_diag_comp(1'b1, 8'd40, 40, 52, 1'b0);
    t_diag_dev1(1'b1);
    t_diag_dev1(1'b0);
    t_abort(1'b0);
    t_abort(1'b1);
    end_of_test();
  end

  // hang guard, well above the few hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge core_clk);
    err_count++;
    $display("CHECK FAILED at %0t: timeout", $time);
    end_of_test();
  end
endmodule : diag_and_device_reset_protocol_test
